// ---- fcr_map.svh ----
// register offsets, field positions and reset values of the configuration slice
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// bus geometry
`define FCR_ADDR_W          12
`define FCR_IDX_W           10

// register indexes; byte address is four times the index
`define FCR_IDX_DUTY_CTL    10'h018
`define FCR_IDX_HIGH_LO     10'h01A
`define FCR_IDX_LOW_HI      10'h01B
`define FCR_IDX_LOW_LO      10'h01C
`define FCR_IDX_LIM_HI      10'h01D
`define FCR_IDX_LIM_LO      10'h01E
`define FCR_IDX_PLL         10'h01F
`define FCR_IDX_FWD         10'h020
`define FCR_IDX_FRAME_LO    10'h024
`define FCR_IDX_FRAME_HI    10'h025

// field positions
`define FCR_DUTY_SEL_BIT    1
`define FCR_PLL_OSC_BIT     3
`define FCR_PLL_RATE_BIT    2
`define FCR_PLL_SPEED_MSB   1
`define FCR_PLL_SPEED_LSB   0
`define FCR_PLL_WR_MASK     8'h0F
`define FCR_FWD_BLOCK_LSB   4
`define FCR_DUTY_WR_MASK    8'h02

// reset values
`define FCR_RST_DUTY_CTL    8'h00
`define FCR_RST_HIGH_LO     8'h00
`define FCR_RST_LOW_HI      8'h00
`define FCR_RST_LOW_LO      8'h00
`define FCR_RST_LIM_HI      8'h00
`define FCR_RST_LIM_LO      8'h04
`define FCR_RST_PLL         8'h02
`define FCR_RST_FWD         8'hF0
`define FCR_RST_FRAME       16'h0000

// bus responses
`define FCR_RESP_OKAY       2'h0
`define FCR_RESP_SLVERR     2'h2

`endif

// ---- fcr_pkg.sv ----
// types shared by the configuration slice and its users
package fcr_pkg;

    // settings handed to the sync generator, forwarder and transmitter pll
    typedef struct packed {
        logic        duty_equal;
        logic [15:0] sync_pulse_low_period;
        logic [23:0] sync_pulse_equal_count;
        logic        ref_source_internal_osc;
        logic        ref_rate_half;
        logic [1:0]  tx_speed;
        logic [3:0]  rx_forward_block;
    } fcr_cfg_t;

    // whole state of the register slice
    typedef struct packed {
        logic        aw_held;
        logic [9:0]  aw_idx;
        logic        w_held;
        logic [7:0]  w_byte;
        logic        w_en;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  duty_ctl;
        logic [7:0]  high_lo;
        logic [7:0]  low_hi;
        logic [7:0]  low_lo;
        logic [7:0]  lim_hi;
        logic [7:0]  lim_lo;
        logic [7:0]  pll;
        logic [7:0]  fwd;
        logic [15:0] frame_num;
    } fcr_state_t;

endpackage

// ---- fcr_config_regs.sv ----
// register slice for frame sync period, frame number wrap, pll and forwarding controls
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "fcr_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] software writes period minus one
// [RQ2] low period bits 7:0 at 0x1C
// [RQ3] low period bits 15:8 at 0x1B
// [RQ4] equal duty uses 24-bit joined count
// [RQ5] frame start/end carry 16-bit number
// [RQ6] limit zero forces frame number zero
// [RQ7] number counts 1 to limit, wraps
// [RQ8] limit bits 15:8 at 0x1D, reset zero
// [RQ9] limit bits 7:0 reset to four
// [RQ10] bit 3 selects internal oscillator reference
// [RQ11] bit 2 halves digital reference rate
// [RQ12] software avoids half rate at 400 Mbps
// [RQ13] bits 1:0 select serial rate, reset 10
// [RQ14] pll control bits 7:4 reserved zero
// [RQ15] bits 7:4 of 0x20 block ports
// [RQ16] all ports blocked after reset
// [RQ17] forwarding bits 3:0 reserved read-write
// [RQ18] start and end share number; restart 1
// [RQ19] reserved bits store, read back written; code stores them at 0x20 only, reserved bits of 0x18 and 0x1F read zero
module fcr_config_regs
(
    input  wire logic                     CLK,
    input  wire logic                     RST_B,
    input  wire logic [`FCR_ADDR_W-1:0]   S_AXI_AWADDR,
    input  wire logic                     S_AXI_AWVALID,
    output      logic                     S_AXI_AWREADY,
    input  wire logic [31:0]              S_AXI_WDATA,
    input  wire logic [3:0]               S_AXI_WSTRB,
    input  wire logic                     S_AXI_WVALID,
    output      logic                     S_AXI_WREADY,
    output      logic [1:0]               S_AXI_BRESP,
    output      logic                     S_AXI_BVALID,
    input  wire logic                     S_AXI_BREADY,
    input  wire logic [`FCR_ADDR_W-1:0]   S_AXI_ARADDR,
    input  wire logic                     S_AXI_ARVALID,
    output      logic                     S_AXI_ARREADY,
    output      logic [31:0]              S_AXI_RDATA,
    output      logic [1:0]               S_AXI_RRESP,
    output      logic                     S_AXI_RVALID,
    input  wire logic                     S_AXI_RREADY,
    input  wire logic                     FRAME_START,
    input  wire logic                     FRAME_END,
    output      logic [15:0]              FRAME_NUMBER,
    output      fcr_pkg::fcr_cfg_t        CFG
);
    import fcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    fcr_state_t  r;
    fcr_state_t  next_r;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic [9:0]  ar_idx;
    logic [15:0] limit;
    logic [3:0]  block_bits;

    ////////////////////////////////////////////////////////////////////////////
    // address helpers

    // register map, byte address is four times the index
    //   0x18  bit 1 equal duty select, other bits read zero
    //   0x1A  high time low byte
    //   0x1B  low period upper byte
    //   0x1C  low period lower byte
    //   0x1D  wrap limit upper byte
    //   0x1E  wrap limit lower byte
    //   0x1F  pll control, upper nibble reads zero
    //   0x20  port forward blocks in 7:4, spare bits in 3:0
    //   0x24  frame number low byte, read only
    //   0x25  frame number high byte, read only
    // any other index answers with a slave error
    function automatic logic idx_writable(input logic [9:0] idx);
        logic ok;
        ok = 1'b0;
        case (idx)
            `FCR_IDX_DUTY_CTL,
            `FCR_IDX_HIGH_LO,
            `FCR_IDX_LOW_HI,
            `FCR_IDX_LOW_LO,
            `FCR_IDX_LIM_HI,
            `FCR_IDX_LIM_LO,
            `FCR_IDX_PLL,
            `FCR_IDX_FWD:
                ok = 1'b1;
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic logic idx_readable(input logic [9:0] idx);
        logic ok;
        ok = idx_writable(idx);
        if ((idx == `FCR_IDX_FRAME_LO) || (idx == `FCR_IDX_FRAME_HI))
        begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    // narrow registers sit in the low byte, upper bits read zero
    function automatic logic [7:0] read_byte(input fcr_state_t s, input logic [9:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `FCR_IDX_DUTY_CTL: v = s.duty_ctl;
            `FCR_IDX_HIGH_LO:  v = s.high_lo;
            `FCR_IDX_LOW_HI:   v = s.low_hi;
            `FCR_IDX_LOW_LO:   v = s.low_lo;
            `FCR_IDX_LIM_HI:   v = s.lim_hi;
            `FCR_IDX_LIM_LO:   v = s.lim_lo;
            `FCR_IDX_PLL:      v = s.pll;
            `FCR_IDX_FWD:      v = s.fwd;
            `FCR_IDX_FRAME_LO: v = s.frame_num[7:0];
            `FCR_IDX_FRAME_HI: v = s.frame_num[15:8];
            default:           v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes

    // write: response rises at the edge after both halves are held
    // read: answer stands from the cycle after the address edge
    assign S_AXI_AWREADY = !r.aw_held && !r.bvalid;
    assign S_AXI_WREADY  = !r.w_held && !r.bvalid;
    assign S_AXI_ARREADY = !r.rvalid;
    assign aw_take       = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take        = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_take       = S_AXI_ARVALID && S_AXI_ARREADY;
    assign ar_idx        = S_AXI_ARADDR[`FCR_ADDR_W-1:2];

    // [RQ8] joined wrap limit
    assign limit = {r.lim_hi, r.lim_lo};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_r = r;

        // address and data may arrive in either order
        if (aw_take)
        begin
            next_r.aw_held = 1'b1;
            next_r.aw_idx  = S_AXI_AWADDR[`FCR_ADDR_W-1:2];
        end
        if (w_take)
        begin
            next_r.w_held = 1'b1;
            next_r.w_byte = S_AXI_WDATA[7:0];
            next_r.w_en   = S_AXI_WSTRB[0];
        end

        // commit once both halves are held
        if (r.aw_held && r.w_held)
        begin
            next_r.aw_held = 1'b0;
            next_r.w_held  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = idx_writable(r.aw_idx) ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
            if (r.w_en)
            begin
                case (r.aw_idx)
                    `FCR_IDX_DUTY_CTL: next_r.duty_ctl = r.w_byte & `FCR_DUTY_WR_MASK;
                    `FCR_IDX_HIGH_LO:  next_r.high_lo = r.w_byte;
                    // [RQ3] period upper byte
                    `FCR_IDX_LOW_HI:   next_r.low_hi = r.w_byte;
                    // [RQ2] period lower byte
                    `FCR_IDX_LOW_LO:   next_r.low_lo = r.w_byte;
                    // [RQ8] limit upper byte
                    `FCR_IDX_LIM_HI:   next_r.lim_hi = r.w_byte;
                    // [RQ9] limit lower byte
                    `FCR_IDX_LIM_LO:   next_r.lim_lo = r.w_byte;
                    // [RQ14] reserved nibble stays zero
                    `FCR_IDX_PLL:      next_r.pll = r.w_byte & `FCR_PLL_WR_MASK;
                    // [RQ17] spare low nibble read-write
                    // [RQ19] reserved bits stored as written
                    `FCR_IDX_FWD:      next_r.fwd = r.w_byte;
                    default:           next_r.fwd = r.fwd;
                endcase
            end
        end
        else if (r.bvalid && S_AXI_BREADY)
        begin
            next_r.bvalid = 1'b0;
        end

        // read answer latched at the address handshake
        if (ar_take)
        begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = {24'h000000, read_byte(r, ar_idx)};
            next_r.rresp  = idx_readable(ar_idx) ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
        end
        else if (r.rvalid && S_AXI_RREADY)
        begin
            next_r.rvalid = 1'b0;
        end

        // [RQ6] numbering disabled holds zero
        if (limit == 16'h0000)
        begin
            next_r.frame_num = 16'h0000;
        end
        // [RQ7] advance per frame and wrap to one
        else if (FRAME_START)
        begin
            // [RQ18] restart at one after reset or re-enable
            if ((r.frame_num == 16'h0000) || (r.frame_num >= limit))
            begin
                next_r.frame_num = 16'h0001;
            end
            else
            begin
                next_r.frame_num = r.frame_num + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            r           <= '0;
            r.duty_ctl  <= `FCR_RST_DUTY_CTL;
            r.high_lo   <= `FCR_RST_HIGH_LO;
            r.low_hi    <= `FCR_RST_LOW_HI;
            r.low_lo    <= `FCR_RST_LOW_LO;
            r.lim_hi    <= `FCR_RST_LIM_HI;
            r.lim_lo    <= `FCR_RST_LIM_LO;
            // [RQ13] serial rate resets to 800 Mbps
            r.pll       <= `FCR_RST_PLL;
            // [RQ16] every port blocked out of reset
            r.fwd       <= `FCR_RST_FWD;
            r.frame_num <= `FCR_RST_FRAME;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus outputs

    assign S_AXI_BVALID = r.bvalid;
    assign S_AXI_BRESP  = r.bresp;
    assign S_AXI_RVALID = r.rvalid;
    assign S_AXI_RDATA  = r.rdata;
    assign S_AXI_RRESP  = r.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // settings to the rest of the hub

    // [RQ5] number shown on start and end packets
    assign FRAME_NUMBER = r.frame_num;

    // [RQ15] one block bit per receive port
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_fwd
            assign block_bits[gi] = r.fwd[`FCR_FWD_BLOCK_LSB + gi];
        end
    endgenerate

    always_comb
    begin
        CFG.duty_equal              = r.duty_ctl[`FCR_DUTY_SEL_BIT];
        // [RQ1] value is period minus one, zero means one cycle
        CFG.sync_pulse_low_period   = {r.low_hi, r.low_lo};
        // [RQ4] equal duty joined count
        CFG.sync_pulse_equal_count  = {r.high_lo, r.low_hi, r.low_lo};
        // [RQ10] reference source select
        CFG.ref_source_internal_osc = r.pll[`FCR_PLL_OSC_BIT];
        // [RQ11] digital reference rate select
        CFG.ref_rate_half           = r.pll[`FCR_PLL_RATE_BIT];
        // [RQ13] transmitter serial rate
        CFG.tx_speed                = r.pll[`FCR_PLL_SPEED_MSB:`FCR_PLL_SPEED_LSB];
        CFG.rx_forward_block        = block_bits;
    end

    // end of frame needs no action: the number stays put until the next start
    logic unused_frame_end;
    assign unused_frame_end = FRAME_END;

endmodule

// ---- fcr_config_regs_assertions.sv ----
// concurrent checks on the ports of the configuration register slice
`timescale 1ns/100ps
module fcr_config_regs_chk
    import fcr_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        FRAME_START,
    input wire logic [15:0] FRAME_NUMBER,
    input wire fcr_pkg::fcr_cfg_t CFG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_reset_cfg: assert property (
        $rose(RST_B) |-> CFG.tx_speed == 2'h2 && CFG.rx_forward_block == 4'hF)
        else $error("config reset value wrong");
    a_num_step: assert property (
        FRAME_START && FRAME_NUMBER != 16'h0 |=>
        FRAME_NUMBER == $past(FRAME_NUMBER) + 16'h1 || FRAME_NUMBER <= 16'h1)
        else $error("frame number did not step");
    a_num_hold: assert property (
        !FRAME_START |=> FRAME_NUMBER == $past(FRAME_NUMBER) || FRAME_NUMBER == 16'h0)
        else $error("frame number moved without a frame");
    a_read_lat: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    a_write_lat: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=>
        !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write answer timing wrong");
    a_b_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_r_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_rdata_byte: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule

// ---- tb_top.sv ----
// self-checking bench for the configuration register slice
`timescale 1ns/100ps
module tb_top;
    import fcr_pkg::*;
    logic        CLK = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fst = 0, fen = 0;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata, cd;
    logic [1:0]  bresp, rresp, cr;
    logic        awr, wrr, bv, arr, rv;
    logic [15:0] fnum;
    fcr_cfg_t    cfg;
    logic [7:0]  m [64];
    logic [7:0]  ll [5] = '{8'h03, 8'h00, 8'h01, 8'h05, 8'h02};
    logic [7:0]  sd = 8'h49, dv;
    logic [3:0]  ws = 4'hF;
    int          miscompares = 0, n_checks = 0, num = 0;
    always #10 CLK = ~CLK;
    fcr_config_regs fcr_config_regs_i (.CLK(CLK), .RST_B(rst_b), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
        .FRAME_START(fst), .FRAME_END(fen), .FRAME_NUMBER(fnum), .CFG(cfg));
    function logic [7:0] lf();
        sd = {sd[6:0], sd[7] ^ sd[5] ^ sd[4] ^ sd[3]};
        return sd;
    endfunction
    // write mask with a writable flag on top
    function logic [8:0] wm(input logic [9:0] i);
        if (i == 10'h18)
            return 9'h102;
        if (i == 10'h1F)
            return 9'h10F;
        if (i inside {[10'h1A:10'h1E], 10'h20})
            return 9'h1FF;
        return 9'h0;
    endfunction
    function int lim();
        return {m[8'h1D], m[8'h1E]};
    endfunction
    // model registers and frame number at their reset values
    task automatic mi();
        for (int i = 0; i < 64; i++)
            m[i] = 8'h0;
        m[8'h1E] = 8'h04;
        m[8'h1F] = 8'h02;
        m[8'h20] = 8'hF0;
        num = 0;
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic ck(input logic [48:0] g, input logic [48:0] e, input string s);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, s);
        end
    endtask
    // wait for a handshake: 0 read address, 1 read data, 2 write response
    task automatic hs(input int w);
        logic t;
        t = 0;
        while (!t)
        begin
            @(negedge CLK);
            t = w == 0 ? arr : w == 1 ? rv : bv;
            cd = rdata;
            cr = w == 2 ? bresp : rresp;
            @(posedge CLK);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [8:0] k;
        logic       pa, pw, ta, tw;
        k = wm(i);
        pa = 1;
        pw = 1;
        awa <= {i, 2'h0};
        wd <= {lf(), lf(), lf(), d};
        awv <= 1;
        wv <= 1;
        while (pa | pw)
        begin
            @(negedge CLK);
            ta = pa & awr;
            tw = pw & wrr;
            @(posedge CLK);
            if (ta)
                awv <= 0;
            if (tw)
                wv <= 0;
            pa = pa & ~ta;
            pw = pw & ~tw;
        end
        repeat (2) @(posedge CLK);
        bry <= 1;
        hs(2);
        bry <= 0;
        if (k[8] && ws[0])
            m[i[5:0]] = d & k[7:0];
        if (lim() == 0)
            num = 0;
        ck(cr, k[8] ? 2'h0 : 2'h2, "write response");
    endtask
    task automatic rd(input logic [9:0] i);
        logic [8:0] k;
        logic [7:0] e;
        k = wm(i);
        e = k[8] ? m[i[5:0]] : i == 10'h24 ? num[7:0] : i == 10'h25 ? num[15:8] : 8'h0;
        ara <= {i, 2'h0};
        arv <= 1;
        hs(0);
        arv <= 0;
        repeat (2) @(posedge CLK);
        rry <= 1;
        hs(1);
        rry <= 0;
        ck(cd, e, "read data");
        ck(cr, k[8] || i inside {10'h24, 10'h25} ? 2'h0 : 2'h2, "read response");
    endtask
    task automatic cc();
        fcr_cfg_t e;
        e = '{m[8'h18][1], {m[8'h1B], m[8'h1C]}, {m[8'h1A], m[8'h1B], m[8'h1C]},
              m[8'h1F][3], m[8'h1F][2], m[8'h1F][1:0], m[8'h20][7:4]};
        ck(cfg, e, "config outputs");
    endtask
    task automatic fs();
        fst <= 1;
        @(posedge CLK);
        fst <= 0;
        fen <= 1;
        num = lim() == 0 ? 0 : (num == 0 || num >= lim()) ? 1 : num + 1;
        @(negedge CLK);
        ck(fnum, num, "frame number");
        @(posedge CLK);
        fen <= 0;
    endtask
    initial
    begin
        mi();
        repeat (20) @(posedge CLK);
        rst_b <= 1;
        @(posedge CLK);
        cc();
        for (int i = 8'h18; i < 8'h27; i++)
            rd(i);
        $display("test reset values done");
        repeat (3)
            for (int i = 8'h18; i < 8'h27; i++)
            begin
                dv = lf();
                // half rate kept off the slowest serial rate
                if (i == 8'h1F && dv[1:0] == 2'h3)
                    dv[2] = 1'b0;
                // any byte is a legal period minus one
                wr(i, dv);
                rd(i);
                cc();
            end
        wr(10'h3FF, lf());
        rd(10'h3FF);
        // strobe low answers but stores nothing
        ws <= 4'h0;
        wr(10'h20, 8'h0F);
        ws <= 4'hF;
        rd(10'h20);
        $display("test register access done");
        wr(10'h1D, 8'h00);
        foreach (ll[j])
        begin
            wr(10'h1E, ll[j]);
            repeat (4) fs();
            rd(10'h24);
            rd(10'h25);
        end
        wr(10'h1D, 8'h01);
        repeat (3) fs();
        $display("test frame numbering done");
        // reset mid-run restarts numbering and registers
        rst_b <= 0;
        repeat (2) @(posedge CLK);
        rst_b <= 1;
        mi();
        @(posedge CLK);
        cc();
        rd(10'h20);
        fs();
        $display("test mid-run reset done");
        end_sim();
    end
    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end
endmodule
bind fcr_config_regs fcr_config_regs_chk fcr_config_regs_chk_i (.CLK(CLK), .RST_B(RST_B),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .FRAME_START(FRAME_START), .FRAME_NUMBER(FRAME_NUMBER),
    .CFG(CFG));
